// ---- gptc_pkg.sv ----
// constants and types shared by the positioning power and timing control block
package gptc_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned PULSE_WIDTH_MS = 100;
    localparam int unsigned PULSE_WIDTH_CYC = PULSE_WIDTH_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int unsigned SUPPLY_SETTLE_US = 1000;
    localparam int unsigned SUPPLY_SETTLE_CYC = SUPPLY_SETTLE_US * 1000 / CLK_PERIOD_NS;

    // ****************************************
    // time keeping
    // ****************************************
    localparam int unsigned SEC_W = 32;
    localparam int unsigned ACC_W = 16;
    localparam logic [7:0] SAT_FRESH_S = 8'h02;
    localparam logic [7:0] SAT_AGE_MAX = 8'hff;
    localparam logic [ACC_W-1:0] SAT_ACC_NS = 16'h0064;
    localparam logic [ACC_W-1:0] CELL_ACC_NS = 16'h2710;

    // ****************************************
    // command codes
    // ****************************************
    localparam logic POS_MODE_OFF = 1'b0;
    localparam logic POS_MODE_ON = 1'b1;
    localparam logic [7:0] FN_TIME_PULSE = 8'h16;
    localparam logic [7:0] FN_TIMESTAMP = 8'h17;
    localparam logic [1:0] RPT_PULSE = 2'h1;
    localparam logic [1:0] RPT_EVENT = 2'h2;

    // ****************************************
    // positioning power sequence
    // ****************************************
    typedef enum logic [2:0] {
        ST_OFF,
        ST_SETTLE,
        ST_RESTORE,
        ST_RUN,
        ST_SAVE
    } gptc_state_t;

endpackage

// ---- gptc_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module gptc_sync
    import gptc_pkg::*;
#(
    parameter int unsigned W = 1
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } gptc_sync_st_t;

    gptc_sync_st_t q;
    gptc_sync_st_t d;

    always_comb begin
        d = q;
        d.s1 = async_in;
        d.s2 = q.s1;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_out = q.s2;

endmodule

// ---- gptc_top.sv ----
// positioning power sequencing, sleep gating and time-keeping unit
// Overview of operation
// - no deep sleep while positioning runs, even in modem power saving
// - mode 0 command switches positioning off under cellular control
// - navigation data saved to flash before positioning power is removed
// - deep sleep only after positioning off and with modem in power saving
// - real-time counter keeps running in sleep and when positioning is off
// - mode 1 reads stored navigation data back and delivers it with current time
// - 26 MHz reference clock supplied whenever positioning runs
// - receiver runs signal processing only once positioning is operative
// - with power saving enabled the cellular side idles whenever possible
// - idle cellular side woken only by receiver data-ready line
// - time-keeping unit tracks and arbitrates satellite and cellular time
// - function 22 gives continuous 1 PPS or a single pulse on pulse pin
// - single pulse sends a report with date, time and accuracy
// - pulse comes from receiver pulse line or cellular time as configured
// - function 23: rising timestamp edge sends a report with event time
// - event stamped with the most accurate time source available
// - positioning unpowered at boot, supplied only after mode 1 command
`timescale 1ns/1ns
module gptc_top
    import gptc_pkg::*;
#(
    parameter int unsigned TICKS_PER_SEC = CLK_HZ,
    parameter int unsigned PULSE_CYC = PULSE_WIDTH_CYC,
    parameter int unsigned SETTLE_CYC = SUPPLY_SETTLE_CYC
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic pos_cmd_valid,
    input wire logic pos_cmd_mode,
    input wire logic power_saving_en,
    input wire logic modem_psm,
    input wire logic drdy_wake_en,
    input wire logic [7:0] pulse_pin_function,
    input wire logic [7:0] stamp_pin_function,
    input wire logic pulse_single_mode,
    input wire logic pulse_single_arm,
    input wire logic pulse_src_cell,
    input wire logic flash_save_done,
    input wire logic flash_load_done,
    input wire logic sat_time_valid,
    input wire logic [SEC_W-1:0] sat_time_sec,
    input wire logic receiver_pulse_line,
    input wire logic receiver_data_ready_line,
    input wire logic event_timestamp_input,
    output logic pos_supply_en,
    output logic ref_clk_en,
    output logic receiver_run_en,
    output logic flash_save_req,
    output logic flash_load_req,
    output logic nav_deliver,
    output logic [SEC_W-1:0] nav_time_sec,
    output logic deep_sleep_allowed,
    output logic idle_allowed,
    output logic cell_wake,
    output logic time_pulse_pin,
    output logic report_valid,
    output logic [1:0] report_kind,
    output logic [SEC_W-1:0] report_sec,
    output logic [31:0] report_tick,
    output logic [ACC_W-1:0] report_acc,
    output logic report_src_sat
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] pins_sync;

    gptc_sync #(.W(3)) u_sync (
        .mclk(mclk),
        .reset(reset),
        .async_in({receiver_pulse_line, receiver_data_ready_line, event_timestamp_input}),
        .sync_out(pins_sync)
    );

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        gptc_state_t st;
        logic [31:0] cnt;
        logic off_pend;
        logic on_pend;
        logic supply;
        logic ref_clk;
        logic run_en;
        logic save_req;
        logic load_req;
        logic deliver;
        logic [SEC_W-1:0] nav_sec;
        logic sleep_ok;
        logic idle_ok;
        logic wake;
        logic [2:0] pins_prev;
        logic [SEC_W-1:0] sec;
        logic [31:0] tick;
        logic [7:0] sat_age;
        logic sat_seen;
        logic pulse;
        logic [31:0] pulse_cnt;
        logic armed;
        logic pend;
        logic [SEC_W-1:0] pend_sec;
        logic [31:0] pend_tick;
        logic pend_sat;
        logic rpt_valid;
        logic [1:0] rpt_kind;
        logic [SEC_W-1:0] rpt_sec;
        logic [31:0] rpt_tick;
        logic rpt_sat;
        logic [ACC_W-1:0] rpt_acc;
    } gptc_st_t;

    gptc_st_t q;
    gptc_st_t d;

    logic sat_edge;
    logic drdy;
    logic ev_edge;
    logic sec_edge;
    logic sat_fresh;
    logic pulse_trig;
    logic fn_pulse;
    logic fn_stamp;
    logic cmd_on;
    logic cmd_off;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d = q;
        d.deliver = 1'b0;
        d.rpt_valid = 1'b0;
        d.pins_prev = pins_sync;
        sat_edge = pins_sync[2] && !q.pins_prev[2] && (q.st == ST_RUN);
        drdy = pins_sync[1];
        ev_edge = pins_sync[0] && !q.pins_prev[0];
        cmd_on = pos_cmd_valid && (pos_cmd_mode == POS_MODE_ON);
        cmd_off = pos_cmd_valid && (pos_cmd_mode == POS_MODE_OFF);
        fn_pulse = (pulse_pin_function == FN_TIME_PULSE);
        fn_stamp = (stamp_pin_function == FN_TIMESTAMP);

        // power sequence
        unique case (q.st)
            ST_OFF: begin
                if (cmd_on || q.on_pend) begin
                    d.st = ST_SETTLE;
                    d.cnt = '0;
                    d.supply = 1'b1;
                    d.ref_clk = 1'b1;
                    d.on_pend = 1'b0;
                    d.off_pend = 1'b0;
                end
            end
            ST_SETTLE: begin
                d.cnt = q.cnt + 32'h1;
                if (cmd_off) begin
                    d.off_pend = 1'b1;
                end
                if (q.cnt == SETTLE_CYC - 1) begin
                    d.st = ST_RESTORE;
                    d.load_req = 1'b1;
                end
            end
            ST_RESTORE: begin
                if (cmd_off) begin
                    d.off_pend = 1'b1;
                end
                if (flash_load_done) begin
                    d.load_req = 1'b0;
                    d.deliver = 1'b1;
                    d.nav_sec = q.sec;
                    d.st = ST_RUN;
                    d.run_en = 1'b1;
                end
            end
            ST_RUN: begin
                if (cmd_off || q.off_pend) begin
                    d.st = ST_SAVE;
                    d.save_req = 1'b1;
                    d.run_en = 1'b0;
                    d.off_pend = 1'b0;
                end
            end
            ST_SAVE: begin
                if (cmd_on) begin
                    d.on_pend = 1'b1;
                end
                if (flash_save_done) begin
                    d.save_req = 1'b0;
                    d.supply = 1'b0;
                    d.ref_clk = 1'b0;
                    d.st = ST_OFF;
                end
            end
        endcase

        // sleep and wake gating
        d.sleep_ok = (d.st == ST_OFF) && modem_psm;
        d.wake = drdy_wake_en && drdy && q.idle_ok;
        d.idle_ok = power_saving_en && !(drdy_wake_en && drdy) &&
            (d.st == ST_OFF || d.st == ST_RUN);

        // free-running time keeping, never gated by sleep or power state
        sec_edge = (q.tick == TICKS_PER_SEC - 1);
        if (sec_edge) begin
            d.tick = '0;
            d.sec = q.sec + 32'h1;
            if (q.sat_age != SAT_AGE_MAX) begin
                d.sat_age = q.sat_age + 8'h01;
            end
        end else begin
            d.tick = q.tick + 32'h1;
        end
        if (sat_edge && sat_time_valid) begin
            d.tick = '0;
            d.sec = sat_time_sec;
            d.sat_age = '0;
            d.sat_seen = 1'b1;
        end
        sat_fresh = d.sat_seen && (d.sat_age < SAT_FRESH_S);

        // time pulse generation
        pulse_trig = fn_pulse && (pulse_src_cell ? sec_edge : sat_edge) &&
            (!pulse_single_mode || q.armed);
        if (q.pulse) begin
            d.pulse_cnt = q.pulse_cnt + 32'h1;
            if (q.pulse_cnt == PULSE_CYC - 1) begin
                d.pulse = 1'b0;
            end
        end
        if (pulse_trig) begin
            d.pulse = 1'b1;
            d.pulse_cnt = '0;
        end
        if (!fn_pulse) begin
            d.pulse = 1'b0;
        end
        d.armed = (q.armed && !(pulse_trig && pulse_single_mode)) || pulse_single_arm;

        // reports, event first and pulse report held one slot behind it
        if (pulse_trig && pulse_single_mode) begin
            d.pend = 1'b1;
            d.pend_sec = d.sec;
            d.pend_tick = d.tick;
            d.pend_sat = !pulse_src_cell;
        end
        if (ev_edge && fn_stamp) begin
            d.rpt_valid = 1'b1;
            d.rpt_kind = RPT_EVENT;
            d.rpt_sec = d.sec;
            d.rpt_tick = d.tick;
            d.rpt_sat = sat_fresh;
            d.rpt_acc = sat_fresh ? SAT_ACC_NS : CELL_ACC_NS;
        end else if (q.pend) begin
            d.rpt_valid = 1'b1;
            d.rpt_kind = RPT_PULSE;
            d.rpt_sec = q.pend_sec;
            d.rpt_tick = q.pend_tick;
            d.rpt_sat = q.pend_sat;
            d.rpt_acc = q.pend_sat ? SAT_ACC_NS : CELL_ACC_NS;
            d.pend = pulse_trig && pulse_single_mode;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign pos_supply_en = q.supply;
    assign ref_clk_en = q.ref_clk;
    assign receiver_run_en = q.run_en;
    assign flash_save_req = q.save_req;
    assign flash_load_req = q.load_req;
    assign nav_deliver = q.deliver;
    assign nav_time_sec = q.nav_sec;
    assign deep_sleep_allowed = q.sleep_ok;
    assign idle_allowed = q.idle_ok;
    assign cell_wake = q.wake;
    assign time_pulse_pin = q.pulse;
    assign report_valid = q.rpt_valid;
    assign report_kind = q.rpt_kind;
    assign report_sec = q.rpt_sec;
    assign report_tick = q.rpt_tick;
    assign report_acc = q.rpt_acc;
    assign report_src_sat = q.rpt_sat;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    a_sleep_no_pos: assert property (
        deep_sleep_allowed |-> !pos_supply_en && !receiver_run_en)
        else $error("deep sleep allowed while positioning powered");

    a_off_saves: assert property (
        (q.st == ST_RUN && pos_cmd_valid && pos_cmd_mode == POS_MODE_OFF)
        |=> flash_save_req && !receiver_run_en)
        else $error("off command did not start navigation save");

    a_save_before_off: assert property (
        $fell(pos_supply_en) |-> $past(flash_save_req) && $past(flash_save_done))
        else $error("supply removed before save completed");

    a_sleep_psm: assert property (
        deep_sleep_allowed |-> $past(modem_psm) && q.st == ST_OFF)
        else $error("deep sleep without modem power saving");

    a_rtc_runs: assert property (
        (q.tick != TICKS_PER_SEC - 1 && !(sat_edge && sat_time_valid))
        |=> q.tick == $past(q.tick) + 32'h1)
        else $error("real-time counter stalled");

    a_restore_deliver: assert property (
        (q.st == ST_RESTORE && flash_load_done)
        |=> nav_deliver && !flash_load_req ##1 !nav_deliver)
        else $error("navigation data not delivered once after load");

    a_refclk_run: assert property (
        (receiver_run_en || flash_load_req) |-> ref_clk_en && pos_supply_en)
        else $error("reference clock missing while positioning active");

    a_boot_supply: assert property (
        $rose(pos_supply_en) |-> $past(q.st) == ST_OFF &&
        ($past(pos_cmd_valid) && $past(pos_cmd_mode) || $past(q.on_pend)))
        else $error("supply raised without mode 1 command");

    a_wake_drdy: assert property (
        cell_wake |-> $past(drdy_wake_en) && $past(drdy) && !idle_allowed)
        else $error("wake without data-ready");

    a_pulse_width: assert property (
        ($rose(time_pulse_pin) && fn_pulse) |-> time_pulse_pin [*4])
        else $error("time pulse shorter than expected");

    a_pulse_gated: assert property (
        !fn_pulse |=> !time_pulse_pin)
        else $error("time pulse active without pulse function");

    a_event_report: assert property (
        (ev_edge && fn_stamp) |=> report_valid && report_kind == RPT_EVENT)
        else $error("timestamp edge produced no event report");

    a_single_report: assert property (
        (pulse_trig && pulse_single_mode) |-> ##[2:3] (report_valid && report_kind == RPT_PULSE))
        else $error("single pulse produced no report");

endmodule

// ---- gptc_partner_model.sv ----
// flash controller and receiver model on the far side of the positioning power and timing block
`timescale 1ns/1ns
module gptc_partner_model #(
    parameter int unsigned PERIOD = 50,
    parameter int unsigned HIGH = 5
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic slow,
    input wire logic receiver_run_en,
    input wire logic flash_save_req,
    input wire logic flash_load_req,
    output logic flash_save_done,
    output logic flash_load_done,
    output logic receiver_pulse_line
);
    int unsigned wait_q;
    int unsigned ph_q;

    // ****************************************
    // flash answers and receiver pulse train
    // ****************************************
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wait_q <= 0;
            ph_q <= 0;
            flash_save_done <= 1'b0;
            flash_load_done <= 1'b0;
            receiver_pulse_line <= 1'b0;
        end else begin
            flash_save_done <= 1'b0;
            flash_load_done <= 1'b0;
            if ((flash_save_req || flash_load_req) && !flash_save_done && !flash_load_done) begin
                if (wait_q >= (slow ? 6 : 0)) begin
                    flash_save_done <= flash_save_req;
                    flash_load_done <= flash_load_req;
                    wait_q <= 0;
                end else begin
                    wait_q <= wait_q + 1;
                end
            end
            ph_q <= (ph_q == PERIOD - 1) ? 0 : ph_q + 1;
            receiver_pulse_line <= receiver_run_en && (ph_q < HIGH);
        end
    end
endmodule

// ---- tb.sv ----
// self-checking testbench of the positioning power and timing block
`timescale 1ns/1ns
module tb
    import gptc_pkg::*;
;
    localparam int unsigned TPS = 50;
    localparam int unsigned PW = 8;
    localparam int unsigned RP = 50;
    logic mclk = 1'b0, reset = 1'b1, slow = 1'b0;
    logic pos_cmd_valid = 1'b0, pos_cmd_mode = 1'b0, power_saving_en = 1'b0, modem_psm = 1'b1;
    logic drdy_wake_en = 1'b0, pulse_single_mode = 1'b0, pulse_single_arm = 1'b0;
    logic pulse_src_cell = 1'b1, sat_time_valid = 1'b0;
    logic receiver_data_ready_line = 1'b0, event_timestamp_input = 1'b0;
    logic [7:0] pulse_pin_function = 8'h00, stamp_pin_function = 8'h00;
    logic [SEC_W-1:0] sat_time_sec = '0, nav_time_sec, report_sec;
    logic flash_save_done, flash_load_done, receiver_pulse_line, pos_supply_en, ref_clk_en;
    logic receiver_run_en, flash_save_req, flash_load_req, nav_deliver, deep_sleep_allowed;
    logic idle_allowed, cell_wake, time_pulse_pin, report_valid, report_src_sat;
    logic [1:0] report_kind;
    logic [31:0] report_tick;
    logic [ACC_W-1:0] report_acc;
    int n_mismatch = 0;
    int checks = 0;
    int w, p, i, hits;
    int cyc = 0;
    logic [31:0] sec_a [2];
    logic [31:0] tick_a [2];

    gptc_top #(.TICKS_PER_SEC(TPS), .PULSE_CYC(PW), .SETTLE_CYC(4)) gptc_top_inst (
        .mclk, .reset, .pos_cmd_valid, .pos_cmd_mode, .power_saving_en, .modem_psm,
        .drdy_wake_en, .pulse_pin_function, .stamp_pin_function, .pulse_single_mode,
        .pulse_single_arm, .pulse_src_cell, .flash_save_done, .flash_load_done,
        .sat_time_valid, .sat_time_sec, .receiver_pulse_line, .receiver_data_ready_line,
        .event_timestamp_input, .pos_supply_en, .ref_clk_en, .receiver_run_en,
        .flash_save_req, .flash_load_req, .nav_deliver, .nav_time_sec, .deep_sleep_allowed,
        .idle_allowed, .cell_wake, .time_pulse_pin, .report_valid, .report_kind,
        .report_sec, .report_tick, .report_acc, .report_src_sat);

    gptc_partner_model #(.PERIOD(RP), .HIGH(5)) gptc_partner_model_inst (
        .mclk, .reset, .slow, .receiver_run_en, .flash_save_req, .flash_load_req,
        .flash_save_done, .flash_load_done, .receiver_pulse_line);

    always #50 mclk = ~mclk;

    always @(posedge mclk) begin
        if (!reset) begin
            cyc <= cyc + 1;
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [ACC_W-1:0] exp_acc(input logic sat);
        return sat ? SAT_ACC_NS : CELL_ACC_NS;
    endfunction

    function automatic logic exp_deep(input logic off, input logic psm);
        return off & psm;
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic step();
        @(posedge mclk);
        #1;
    endtask

    task automatic cmd(input logic m);
        @(posedge mclk);
        pos_cmd_valid <= 1'b1;
        pos_cmd_mode <= m;
        @(posedge mclk);
        pos_cmd_valid <= 1'b0;
        step();
    endtask

    task automatic measure();
        i = 0;
        while (time_pulse_pin !== 1'b1 && i < 200) begin step(); i++; end
        w = 0;
        p = 0;
        while (time_pulse_pin === 1'b1 && p < 200) begin step(); w++; p++; end
        while (time_pulse_pin !== 1'b1 && p < 200) begin step(); p++; end
    endtask

    task automatic await_report();
        i = 0;
        while (report_valid !== 1'b1 && i < 80) begin step(); i++; end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(20000 * 100);
        n_mismatch++;
        $display("watchdog expired");
        report_and_stop();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        void'($urandom(32'ha12c034e));
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        step();
        check("outputs after reset", {pos_supply_en, ref_clk_en, receiver_run_en}, 0);
        $display("test reset done");
        slow <= 1'($urandom);
        cmd(1'b1);
        check("supply on", pos_supply_en, 1);
        check("ref clock on", ref_clk_en, 1);
        i = 0;
        while (nav_deliver !== 1'b1 && i < 40) begin step(); i++; end
        check("nav delivered", nav_deliver, 1);
        check("nav time", nav_time_sec, (cyc - 1) / TPS);
        check("receiver run", receiver_run_en, 1);
        check("no deep sleep in run", deep_sleep_allowed, 0);
        step();
        check("nav deliver one cycle", nav_deliver, 0);
        $display("test power on done");
        pulse_pin_function <= FN_TIME_PULSE;
        measure();
        measure();
        check("cell pulse width", w, PW);
        check("cell pulse period", p, TPS);
        repeat (10) step();
        pulse_single_mode <= 1'b1;
        hits = 0;
        repeat (120) begin step(); hits += time_pulse_pin; end
        check("single without arm", hits, 0);
        @(posedge mclk);
        pulse_single_arm <= 1'b1;
        @(posedge mclk);
        pulse_single_arm <= 1'b0;
        await_report();
        check("single report kind", report_kind, RPT_PULSE);
        check("single report acc", report_acc, exp_acc(1'b0));
        $display("test cell pulse done");
        pulse_single_mode <= 1'b0;
        pulse_src_cell <= 1'b0;
        sat_time_valid <= 1'b1;
        sat_time_sec <= $urandom;
        stamp_pin_function <= FN_TIMESTAMP;
        measure();
        measure();
        check("sat pulse width", w, PW);
        check("sat pulse period", p, RP);
        @(posedge mclk);
        event_timestamp_input <= 1'b1;
        await_report();
        check("event kind", report_kind, RPT_EVENT);
        check("event src", report_src_sat, 1);
        check("event acc", report_acc, exp_acc(1'b1));
        check("event sec", report_sec, sat_time_sec);
        event_timestamp_input <= 1'b0;
        $display("test sat time done");
        pulse_pin_function <= 8'($urandom_range(0, 21));
        stamp_pin_function <= 8'($urandom_range(24, 255));
        repeat (2) step();
        hits = 0;
        for (int k = 0; k < 100; k++) begin
            @(posedge mclk);
            event_timestamp_input <= k[2];
            #1;
            hits += time_pulse_pin + report_valid;
        end
        check("no function selected", hits, 0);
        $display("test unselected done");
        pulse_pin_function <= FN_TIME_PULSE;
        stamp_pin_function <= FN_TIMESTAMP;
        pulse_src_cell <= 1'b1;
        cmd(1'b0);
        check("save request", flash_save_req, 1);
        check("supply held in save", pos_supply_en, 1);
        check("receiver stopped", receiver_run_en, 0);
        i = 0;
        while (flash_save_req === 1'b1 && i < 40) begin step(); i++; end
        check("supply off", pos_supply_en, 0);
        check("ref clock off", ref_clk_en, 0);
        step();
        check("deep sleep when off", deep_sleep_allowed, exp_deep(1'b1, modem_psm));
        modem_psm <= 1'b0;
        repeat (2 * TPS) step();
        check("no deep sleep out of psm", deep_sleep_allowed, exp_deep(1'b1, 1'b0));
        fork
            begin
                @(posedge mclk);
                event_timestamp_input <= 1'b1;
                repeat (5) @(posedge mclk);
                event_timestamp_input <= 1'b0;
                repeat (TPS - 5) @(posedge mclk);
                event_timestamp_input <= 1'b1;
                repeat (5) @(posedge mclk);
                event_timestamp_input <= 1'b0;
            end
            for (int k = 0; k < 2; k++) begin
                await_report();
                sec_a[k] = report_sec;
                tick_a[k] = report_tick;
                check("cell event src", report_src_sat, 0);
                check("cell event acc", report_acc, exp_acc(1'b0));
                step();
            end
        join
        check("seconds advance", sec_a[1] - sec_a[0], 1);
        check("tick phase kept", tick_a[1], tick_a[0]);
        $display("test power off done");
        power_saving_en <= 1'b1;
        drdy_wake_en <= 1'b1;
        repeat (3) step();
        check("idle allowed", idle_allowed, 1);
        @(posedge mclk);
        receiver_data_ready_line <= 1'b1;
        repeat (3) step();
        check("data ready wakes", cell_wake, 1);
        check("idle left", idle_allowed, 0);
        receiver_data_ready_line <= 1'b0;
        drdy_wake_en <= 1'b0;
        repeat (4) step();
        receiver_data_ready_line <= 1'b1;
        repeat (5) step();
        check("wake disabled", cell_wake, 0);
        $display("test idle wake done");
        report_and_stop();
    end
endmodule
